// ---- flash_erase_host.sv ----
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module flash_erase_host (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n,
    output logic [19:0] flash_addr,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe_n,
    input wire logic [7:0] flash_dq_in,
    output logic reset_powerdown_n
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_CMD1 = 4'b0001,
        ST_GAP = 4'b0010,
        ST_CMD2 = 4'b0011,
        ST_RD_CMD = 4'b0100,
        ST_RD_GAP = 4'b0101,
        ST_RD = 4'b0110,
        ST_RD_END = 4'b0111
    } seq_type;

    seq_type state_r, state_nxt;
    flash_erase_host_pkg::flash_bus_type bus_r, bus_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [2:0] op_r, op_nxt;
    logic [19:0] addr_r, addr_nxt;
    logic [7:0] devstat_r, devstat_nxt;
    logic busy_r, busy_nxt;
    logic refused_r, refused_nxt;
    logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
    logic [31:0] awa_r, awa_nxt, wd_r, wd_nxt, rd_r, rd_nxt;
    logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
    logic rst_r;
    logic [7:0] dq_s1_r, dq_s2_r;

    function automatic logic [7:0] first_cmd(input logic [2:0] op);
        unique case (op)
            flash_erase_host_pkg::OP_ERASE: first_cmd = flash_erase_host_pkg::CMD_ERASE_SETUP;
            flash_erase_host_pkg::OP_SUSPEND: first_cmd = flash_erase_host_pkg::CMD_SUSPEND;
            // no program is ever issued, so resume is always legal
            flash_erase_host_pkg::OP_RESUME: first_cmd = flash_erase_host_pkg::CMD_CONFIRM;
            flash_erase_host_pkg::OP_CLEAR: first_cmd = flash_erase_host_pkg::CMD_CLEAR_STATUS;
            flash_erase_host_pkg::OP_STATUS: first_cmd = flash_erase_host_pkg::CMD_READ_STATUS;
            default: first_cmd = flash_erase_host_pkg::CMD_READ_ARRAY;
        endcase
    endfunction

    // Pin input synchroniser
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dq_s1_r <= 8'h00;
            dq_s2_r <= 8'h00;
            rst_r <= 1'b0;
        end
        else
        begin
            dq_s1_r <= flash_dq_in;
            dq_s2_r <= dq_s1_r;
            rst_r <= 1'b1;
        end
    end

    always_comb
    begin
        logic wr_go;
        logic [7:0] off;
        logic [2:0] new_op;
        wr_go = 1'b0;
        off = 8'h00;
        new_op = op_r;
        state_nxt = state_r;
        bus_nxt = bus_r;
        cnt_nxt = cnt_r;
        op_nxt = op_r;
        addr_nxt = addr_r;
        devstat_nxt = devstat_r;
        busy_nxt = busy_r;
        refused_nxt = refused_r;
        aw_nxt = aw_r;
        w_nxt = w_r;
        bv_nxt = bv_r;
        rv_nxt = rv_r;
        awa_nxt = awa_r;
        wd_nxt = wd_r;
        rd_nxt = rd_r;
        br_nxt = br_r;
        rr_nxt = rr_r;
        // Write channels taken independently
        if (s_axi_awvalid && !aw_r && !bv_r)
        begin
            aw_nxt = 1'b1;
            awa_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_r && !bv_r)
        begin
            w_nxt = 1'b1;
            wd_nxt = s_axi_wdata;
        end
        if (aw_r && w_r && !bv_r)
        begin
            wr_go = 1'b1;
            aw_nxt = 1'b0;
            w_nxt = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = flash_erase_host_pkg::RESP_OKAY;
            off = awa_r[7:0];
            if (off == flash_erase_host_pkg::REG_CTRL)
            begin
                new_op = wd_r[2:0];
                // no erase while supply low is reported
                if (busy_r || new_op == 3'h0 || new_op > flash_erase_host_pkg::OP_STATUS
                    || (new_op == flash_erase_host_pkg::OP_ERASE
                    && devstat_r[flash_erase_host_pkg::SUPPLY_LOW_BIT]))
                    refused_nxt = 1'b1;
                else
                begin
                    op_nxt = new_op;
                    if (new_op == flash_erase_host_pkg::OP_CLEAR)
                        devstat_nxt[flash_erase_host_pkg::SUPPLY_LOW_BIT] = 1'b0;
                    busy_nxt = 1'b1;
                    refused_nxt = 1'b0;
                    state_nxt = ST_CMD1;
                    cnt_nxt = flash_erase_host_pkg::STROBE_CNT;
                    bus_nxt.ce_n = 1'b0;
                    bus_nxt.we_n = 1'b0;
                    bus_nxt.oe_n = 1'b1;
                    bus_nxt.dq_oe_n = 1'b0;
                    bus_nxt.addr = addr_r;
                    bus_nxt.dq_out = first_cmd(new_op);
                end
            end
            else if (off == flash_erase_host_pkg::REG_ADDR)
            begin
                if (!busy_r)
                    addr_nxt = wd_r[19:0];
            end
            else
                br_nxt = flash_erase_host_pkg::RESP_SLVERR;
        end
        if (bv_r && s_axi_bready)
            bv_nxt = 1'b0;
        if (s_axi_arvalid && !rv_r)
        begin
            rv_nxt = 1'b1;
            rr_nxt = flash_erase_host_pkg::RESP_OKAY;
            unique case (s_axi_araddr[7:0])
                flash_erase_host_pkg::REG_CTRL: rd_nxt = {29'h0, op_r};
                flash_erase_host_pkg::REG_ADDR: rd_nxt = {12'h0, addr_r};
                flash_erase_host_pkg::REG_STATUS: rd_nxt = {30'h0, refused_r, busy_r};
                flash_erase_host_pkg::REG_DEVSTAT: rd_nxt = {24'h0, devstat_r};
                default:
                begin
                    rd_nxt = 32'h0;
                    rr_nxt = flash_erase_host_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (rv_r && s_axi_rready)
            rv_nxt = 1'b0;
        // Strobe sequencer
        if (cnt_r != 4'h0)
            cnt_nxt = cnt_r - 4'h1;
        else
        begin
            unique case (state_r)
                ST_IDLE:
                begin
                end
                ST_CMD1, ST_CMD2, ST_RD_CMD:
                begin
                    bus_nxt.we_n = 1'b1;
                    bus_nxt.ce_n = 1'b1;
                    cnt_nxt = flash_erase_host_pkg::STROBE_CNT;
                    if (state_r == ST_CMD1 && op_r == flash_erase_host_pkg::OP_ERASE)
                        state_nxt = ST_GAP;
                    else if (op_r == flash_erase_host_pkg::OP_STATUS && state_r == ST_CMD1)
                        state_nxt = ST_RD_GAP;
                    else
                        state_nxt = ST_RD_END;
                end
                ST_GAP:
                begin
                    state_nxt = ST_CMD2;
                    cnt_nxt = flash_erase_host_pkg::STROBE_CNT;
                    bus_nxt.ce_n = 1'b0;
                    bus_nxt.we_n = 1'b0;
                    bus_nxt.addr = addr_r;
                    bus_nxt.dq_out = flash_erase_host_pkg::CMD_CONFIRM;
                end
                ST_RD_GAP:
                begin
                    // toggle output strobe for fresh status
                    state_nxt = ST_RD;
                    cnt_nxt = flash_erase_host_pkg::STROBE_CNT;
                    bus_nxt.dq_oe_n = 1'b1;
                    bus_nxt.ce_n = 1'b0;
                    bus_nxt.oe_n = 1'b0;
                end
                ST_RD:
                begin
                    devstat_nxt = dq_s2_r;
                    bus_nxt.ce_n = 1'b1;
                    bus_nxt.oe_n = 1'b1;
                    state_nxt = ST_RD_END;
                    cnt_nxt = flash_erase_host_pkg::STROBE_CNT;
                end
                default:
                begin
                    bus_nxt.dq_oe_n = 1'b1;
                    busy_nxt = 1'b0;
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= ST_IDLE;
            bus_r <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 20'h0, dq_out: 8'h00,
                       dq_oe_n: 1'b1};
            cnt_r <= 4'h0;
            op_r <= 3'h0;
            addr_r <= 20'h0;
            devstat_r <= 8'h00;
            busy_r <= 1'b0;
            refused_r <= 1'b0;
            aw_r <= 1'b0;
            w_r <= 1'b0;
            bv_r <= 1'b0;
            rv_r <= 1'b0;
            awa_r <= 32'h0;
            wd_r <= 32'h0;
            rd_r <= 32'h0;
            br_r <= 2'h0;
            rr_r <= 2'h0;
        end
        else
        begin
            state_r <= state_nxt;
            bus_r <= bus_nxt;
            cnt_r <= cnt_nxt;
            op_r <= op_nxt;
            addr_r <= addr_nxt;
            devstat_r <= devstat_nxt;
            busy_r <= busy_nxt;
            refused_r <= refused_nxt;
            aw_r <= aw_nxt;
            w_r <= w_nxt;
            bv_r <= bv_nxt;
            rv_r <= rv_nxt;
            awa_r <= awa_nxt;
            wd_r <= wd_nxt;
            rd_r <= rd_nxt;
            br_r <= br_nxt;
            rr_r <= rr_nxt;
        end
    end

    assign s_axi_awready = !aw_r && !bv_r;
    assign s_axi_wready = !w_r && !bv_r;
    assign s_axi_bvalid = bv_r;
    assign s_axi_bresp = br_r;
    assign s_axi_arready = !rv_r;
    assign s_axi_rvalid = rv_r;
    assign s_axi_rdata = rd_r;
    assign s_axi_rresp = rr_r;
    assign flash_ce_n = bus_r.ce_n;
    assign flash_we_n = bus_r.we_n;
    assign flash_oe_n = bus_r.oe_n;
    assign flash_addr = bus_r.addr;
    assign flash_dq_out = bus_r.dq_out;
    assign flash_dq_oe_n = bus_r.dq_oe_n;
    assign reset_powerdown_n = rst_r;

    property p_confirm_follows;
        @(posedge clk) disable iff (!arst_n)
        (state_r == ST_GAP && cnt_r == 4'h0) |=>
        (flash_dq_out == flash_erase_host_pkg::CMD_CONFIRM && !flash_we_n);
    endproperty
    a_confirm_follows: assert property (p_confirm_follows) else $error("confirm missing");
    property p_we_rise;
        @(posedge clk) disable iff (!arst_n)
        $rose(flash_we_n) |-> $past(state_r) inside {ST_CMD1, ST_CMD2, ST_RD_CMD};
    endproperty
    a_we_rise: assert property (p_we_rise) else $error("stray write strobe");
    property p_addr_stable;
        @(posedge clk) disable iff (!arst_n)
        (!flash_we_n && !flash_ce_n) |-> $stable(flash_addr) or $fell(flash_we_n);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved");
    property p_suspend_code;
        @(posedge clk) disable iff (!arst_n)
        ($fell(flash_we_n) && op_r == flash_erase_host_pkg::OP_SUSPEND) |->
        flash_dq_out == flash_erase_host_pkg::CMD_SUSPEND;
    endproperty
    a_suspend_code: assert property (p_suspend_code) else $error("bad suspend");
    property p_resume_code;
        @(posedge clk) disable iff (!arst_n)
        ($fell(flash_we_n) && op_r == flash_erase_host_pkg::OP_RESUME) |->
        flash_dq_out == flash_erase_host_pkg::CMD_CONFIRM;
    endproperty
    a_resume_code: assert property (p_resume_code) else $error("bad resume");
    property p_bank_bit;
        @(posedge clk) disable iff (!arst_n)
        $fell(flash_we_n) |->
        flash_addr[flash_erase_host_pkg::BANK_BIT] == addr_r[flash_erase_host_pkg::BANK_BIT];
    endproperty
    a_bank_bit: assert property (p_bank_bit) else $error("bank bit wrong");
    property p_read_array;
        @(posedge clk) disable iff (!arst_n)
        ($fell(flash_we_n) && op_r == flash_erase_host_pkg::OP_READ_ARRAY) |->
        flash_dq_out == flash_erase_host_pkg::CMD_READ_ARRAY;
    endproperty
    a_read_array: assert property (p_read_array) else $error("bad read array");
    property p_oe_read;
        @(posedge clk) disable iff (!arst_n)
        !flash_oe_n |-> flash_dq_oe_n && flash_we_n;
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("bus fight");
    c_erase: cover property (@(posedge clk) state_r == ST_CMD2);
    c_status: cover property (@(posedge clk) state_r == ST_RD);
    c_refused: cover property (@(posedge clk) refused_r);
endmodule

// ---- flash_erase_host_pkg.sv ----
package flash_erase_host_pkg;
    // Device command codes
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    // Device status bit positions, bank address bit and address width
    localparam int READY_BIT = 7;
    localparam int SUSP_BIT = 6;
    localparam int ERASE_ERR_BIT = 5;
    localparam int PROG_ERR_BIT = 4;
    localparam int SUPPLY_LOW_BIT = 3;
    localparam int BANK_BIT = 19;
    localparam int ADDR_W = 20;
    // Own registers, byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_DEVSTAT = 8'h0C;
    // Control field encodings and AXI response codes
    localparam logic [2:0] OP_ERASE = 3'h1;
    localparam logic [2:0] OP_SUSPEND = 3'h2;
    localparam logic [2:0] OP_RESUME = 3'h3;
    localparam logic [2:0] OP_READ_ARRAY = 3'h4;
    localparam logic [2:0] OP_CLEAR = 3'h5;
    localparam logic [2:0] OP_STATUS = 3'h6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Strobe timing
    localparam int CLK_NS = 10;
    localparam int STROBE_NS = 60;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [ADDR_W-1:0] addr;
        logic [7:0] dq_out;
        logic dq_oe_n;
    } flash_bus_type;
endpackage

// ---- flash_dev_model.sv ----
`timescale 1ns/100ps
module flash_dev_model #(
    parameter int ERASE_CYC = 400
) (
    input wire logic clk,
    input wire logic reset_powerdown_n,
    input wire logic vpp_low,
    input wire flash_erase_host_pkg::flash_bus_type bus,
    output logic [7:0] dq_in
);
    logic [7:0] stat [2];
    logic [7:0] cmd_q;
    logic [7:0] last_rd = 8'h00;
    logic [19:0] adr_q, erase_addr;
    logic setup, stat_mode, b;
    int cnt [2];
    int ev = 0;
    int seen;
    wire rd_en = !bus.ce_n && !bus.oe_n;
    assign dq_in = rd_en ? (stat_mode ? stat[bus.addr[19]] : 8'hFF) : ~last_rd;
    always @(posedge (bus.ce_n | bus.we_n))
        if (reset_powerdown_n)
        begin
            cmd_q = bus.dq_out;
            adr_q = bus.addr;
            ev = ev + 1;
        end
    always @(posedge clk or negedge reset_powerdown_n)
        if (!reset_powerdown_n)
        begin
            for (int i = 0; i < 2; i++)
            begin
                stat[i] <= 8'h80;
                cnt[i] <= 0;
            end
            setup <= 0;
            stat_mode <= 0;
            seen <= ev;
        end
        else
        begin
            if (rd_en)
                last_rd <= dq_in;
            for (int i = 0; i < 2; i++)
                if (cnt[i] > 0 && !stat[i][6])
                begin
                    cnt[i] <= cnt[i] - 1;
                    stat[i][7] <= (cnt[i] == 1);
                end
            if (seen != ev)
            begin
                seen <= ev;
                b = adr_q[19];
                setup <= 0;
                if (cmd_q == 8'h70)
                    stat_mode <= 1;
                // busy bank takes status and suspend
                else if (!stat[b][7])
                begin
                    if (cmd_q == 8'hB0)
                        stat[b][7:6] <= 2'b11;
                end
                // suspended bank ignores program and erase
                else if (stat[b][6])
                begin
                    if (cmd_q == 8'hD0)
                        stat[b][7:6] <= 2'b00;
                    if (cmd_q == 8'hFF)
                        stat_mode <= 0;
                end
                else if (cmd_q == 8'h20)
                    setup <= 1;
                else if (cmd_q == 8'hD0 && setup)
                begin
                    // low supply refuses erase and flags it
                    if (vpp_low || stat[b][3])
                        stat[b][3] <= 1'b1;
                    else
                    begin
                        stat[b][7] <= 0;
                        cnt[b] <= ERASE_CYC;
                        erase_addr <= adr_q;
                    end
                end
                else if (cmd_q == 8'hFF)
                    stat_mode <= 0;
                else if (cmd_q == 8'h50)
                    stat[b][5:3] <= 3'b000;
            end
        end
endmodule

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
    logic clk = 0;
    logic arst_n = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic vpp_low = 0;
    logic awready, wready, bvalid, arready, rvalid, rpd_n, dq_oe_n, ce_n, we_n, oe_n;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rv;
    logic [19:0] fa, a;
    logic [7:0] dq_o, dq_i;
    int errors = 0;
    int n_checks = 0;
    int i;
    flash_erase_host_pkg::flash_bus_type bus;
    assign bus = {ce_n, we_n, oe_n, fa, dq_o, dq_oe_n};
    always #5 clk = ~clk;
    flash_erase_host flash_erase_host_inst (
        .clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_addr(fa),
        .flash_dq_out(dq_o), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_i),
        .reset_powerdown_n(rpd_n));
    flash_dev_model #(.ERASE_CYC(400)) flash_dev_model_inst (
        .clk(clk), .reset_powerdown_n(rpd_n), .vpp_low(vpp_low), .bus(bus), .dq_in(dq_i));
    function automatic logic [31:0] st(input logic rdy, input logic sus);
        return {24'h0, rdy, sus, 6'h00};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic hang();
        errors++;
        $display("mismatch at %0t: wait timed out", $time);
        tally_and_finish();
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
        int j;
        @(posedge clk);
        awaddr <= {24'h0, ad};
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (j = 0; j < 40; j++)
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 0;
            if (wready)
                wvalid <= 0;
            if (bvalid)
                break;
        end
        bready <= 0;
        if (j == 40)
            hang();
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] ad, input logic [1:0] er);
        int j;
        @(posedge clk);
        araddr <= {24'h0, ad};
        arvalid <= 1;
        rready <= 1;
        for (j = 0; j < 40; j++)
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 0;
            if (rvalid)
                break;
        end
        rv = rdata;
        rready <= 0;
        if (j == 40)
            hang();
        chk(32'(rresp), 32'(er));
    endtask
    task automatic op(input logic [2:0] o, input logic [19:0] ad);
        int j;
        wr(flash_erase_host_pkg::REG_ADDR, 32'(ad), 2'h0);
        wr(flash_erase_host_pkg::REG_CTRL, 32'(o), 2'h0);
        for (j = 0; j < 60; j++)
        begin
            rd(flash_erase_host_pkg::REG_STATUS, 2'h0);
            if (rv[0] === 1'b0)
                break;
        end
        if (j == 60)
            hang();
    endtask
    task automatic dstat(input logic [19:0] ad);
        op(flash_erase_host_pkg::OP_STATUS, ad);
        rd(flash_erase_host_pkg::REG_DEVSTAT, 2'h0);
    endtask
    initial
    begin
        void'($urandom(32'hF49D));
        repeat (5) @(posedge clk);
        chk(32'(rpd_n), 32'h0);
        arst_n <= 1;
        repeat (2) @(posedge clk);
        chk(32'(rpd_n), 32'h1);
        rd(flash_erase_host_pkg::REG_STATUS, 2'h0);
        chk(rv, 32'h0);
        dstat(20'h0);
        chk(rv, st(1, 0));
        for (int k = 0; k < 3; k++)
        begin
            a = (k == 0) ? 20'hFFFFF : 20'($urandom);
            op(flash_erase_host_pkg::OP_ERASE, a);
            chk(32'(flash_dev_model_inst.erase_addr), 32'(a));
            dstat(a);
            chk(rv, st(0, 0));
            dstat(a ^ 20'h80000);
            chk(rv, st(1, 0));
            op(flash_erase_host_pkg::OP_SUSPEND, a);
            dstat(a);
            chk(rv, st(1, 1));
            op(flash_erase_host_pkg::OP_RESUME, a);
            dstat(a);
            chk(rv, st(0, 0));
            for (i = 0; i < 40 && rv[7] !== 1'b1; i++)
                dstat(a);
            chk(rv, st(1, 0));
        end
        wr(flash_erase_host_pkg::REG_CTRL, 32'(flash_erase_host_pkg::OP_STATUS), 2'h0);
        wr(flash_erase_host_pkg::REG_CTRL, 32'(flash_erase_host_pkg::OP_STATUS), 2'h0);
        rd(flash_erase_host_pkg::REG_STATUS, 2'h0);
        chk(32'(rv[1]), 32'h1);
        for (i = 0; i < 60 && rv[0] !== 1'b0; i++)
            rd(flash_erase_host_pkg::REG_STATUS, 2'h0);
        if (i == 60)
            hang();
        op(flash_erase_host_pkg::OP_READ_ARRAY, 20'h0);
        chk(32'(flash_dev_model_inst.stat_mode), 32'h0);
        for (int k = 0; k < 2; k++)
        begin
            wr(flash_erase_host_pkg::REG_CTRL, (k == 0) ? 32'h0 : 32'h7, 2'h0);
            rd(flash_erase_host_pkg::REG_STATUS, 2'h0);
            chk(32'(rv[1]), 32'h1);
        end
        wr(8'h10, 32'h0, flash_erase_host_pkg::RESP_SLVERR);
        rd(8'h10, flash_erase_host_pkg::RESP_SLVERR);
        chk(rv, 32'h0);
        vpp_low <= 1;
        op(flash_erase_host_pkg::OP_ERASE, 20'h00000);
        dstat(20'h0);
        chk(rv, st(1, 0) | (32'h1 << flash_erase_host_pkg::SUPPLY_LOW_BIT));
        vpp_low <= 0;
        wr(flash_erase_host_pkg::REG_CTRL, 32'(flash_erase_host_pkg::OP_ERASE), 2'h0);
        rd(flash_erase_host_pkg::REG_STATUS, 2'h0);
        chk(32'(rv[1]), 32'h1);
        op(flash_erase_host_pkg::OP_CLEAR, 20'h0);
        dstat(20'h0);
        chk(rv, st(1, 0));
        op(flash_erase_host_pkg::OP_ERASE, 20'h00000);
        @(posedge clk);
        arst_n <= 0;
        @(posedge clk);
        chk(32'(rpd_n), 32'h0);
        arst_n <= 1;
        repeat (2) @(posedge clk);
        dstat(20'h0);
        chk(rv, st(1, 0));
        tally_and_finish();
    end
endmodule
